/* core/adcrt_cfg.svh */
// Timing and width constants for the conversion readout sequencer
`ifndef ADCRT_CFG_SVH
`define ADCRT_CFG_SVH
`define ADCRT_CLK_NS 40
`define ADCRT_RES_BITS 14
// Busy / conversion time, longest, per speed mode
`define ADCRT_T_CONV_FAST_NS 850
`define ADCRT_T_CONV_NORM_NS 1100
`define ADCRT_T_CONV_LOWP_NS 1350
`define ADCRT_CONV_FAST_CYC (`ADCRT_T_CONV_FAST_NS / `ADCRT_CLK_NS)
`define ADCRT_CONV_NORM_CYC (`ADCRT_T_CONV_NORM_NS / `ADCRT_CLK_NS)
`define ADCRT_CONV_LOWP_CYC (`ADCRT_T_CONV_LOWP_NS / `ADCRT_CLK_NS)
// Frame sync delay, read during conversion
`define ADCRT_T_SDUR_FAST_NS 50
`define ADCRT_T_SDUR_NORM_NS 290
`define ADCRT_T_SDUR_LOWP_NS 530
`define ADCRT_SDUR_FAST_CYC (`ADCRT_T_SDUR_FAST_NS / `ADCRT_CLK_NS)
`define ADCRT_SDUR_NORM_CYC (`ADCRT_T_SDUR_NORM_NS / `ADCRT_CLK_NS)
`define ADCRT_SDUR_LOWP_CYC (`ADCRT_T_SDUR_LOWP_NS / `ADCRT_CLK_NS)
// Frame sync delay, read after conversion
`define ADCRT_T_SAFT_FAST_NS 710
`define ADCRT_T_SAFT_NORM_NS 950
`define ADCRT_T_SAFT_LOWP_NS 1190
`define ADCRT_SAFT_FAST_CYC (`ADCRT_T_SAFT_FAST_NS / `ADCRT_CLK_NS)
`define ADCRT_SAFT_NORM_CYC (`ADCRT_T_SAFT_NORM_NS / `ADCRT_CLK_NS)
`define ADCRT_SAFT_LOWP_CYC (`ADCRT_T_SAFT_LOWP_NS / `ADCRT_CLK_NS)
// Least data-valid lead before busy falls; rounded up
`define ADCRT_T_DLEAD_NS 20
`define ADCRT_DLEAD_CYC ((`ADCRT_T_DLEAD_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS)
// Strobe pin to start detect; phase slack of the first stage sits in the data lead
`define ADCRT_PIN_LAT_CYC 3
// Sync to first clock edge, last edge to sync, sync low to busy low
`define ADCRT_T_SYNC_LEAD_NS 3
`define ADCRT_T_SYNC_TAIL_NS 5
`define ADCRT_T_SYNC_BUSY_NS 25
`define ADCRT_SYNC_LEAD_CYC ((`ADCRT_T_SYNC_LEAD_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS)
`define ADCRT_SYNC_TAIL_CYC ((`ADCRT_T_SYNC_TAIL_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS)
`define ADCRT_SYNC_BUSY_CYC ((`ADCRT_T_SYNC_BUSY_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS)
`define ADCRT_RESULT_RST 14'h0000
`endif

/* core/adcrt_pkg.sv */
// Types shared by the conversion readout sequencer
package adcrt_pkg;
   typedef enum logic [1:0] {
      ADCRT_SPD_FAST = 2'h0,
      ADCRT_SPD_NORM = 2'h1,
      ADCRT_SPD_LOWP = 2'h2
   } adcrt_speed_t;
   typedef enum logic [1:0] {
      ADCRT_RD_PAR = 2'h0,
      ADCRT_RD_SER_DURING = 2'h1,
      ADCRT_RD_SER_AFTER = 2'h2
   } adcrt_read_t;
   typedef struct packed {
      logic frame_sync;
      logic serial_data_clock;
      logic serial_data_out;
   } adcrt_ser_t;
endpackage : adcrt_pkg

/* core/adcrt_shifter.sv */
// Master serial frame generator: sync, divided clock, data MSB first
`timescale 1ns/10ps
`include "adcrt_cfg.svh"
module adcrt_shifter #(
   parameter int WIDTH = `ADCRT_RES_BITS
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [WIDTH-1:0] data,
   input wire logic [1:0] div,
   output adcrt_pkg::adcrt_ser_t ser,
   output logic done
);
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_LEAD = 5'h02,
      S_LOW = 5'h04,
      S_HIGH = 5'h08,
      S_TAIL = 5'h10
   } adcrt_sh_state_t;

   adcrt_sh_state_t state_ff, nxt_state;
   logic [WIDTH-1:0] shreg_ff, nxt_shreg;
   logic [7:0] half_ff, nxt_half;
   logic [4:0] bits_ff, nxt_bits;
   logic [1:0] div_ff;
   // A 40 ns clock cannot go below 80 ns, so settings 00 and 01 share it
   wire logic [7:0] half_len = (div_ff == 2'h0) ? 8'h01 : ((8'h01 << div_ff) >> 1);
   wire logic [7:0] half_last = half_len - 8'h01;
   wire logic half_end = (half_ff == half_last);
   wire logic last_bit = (bits_ff == 5'(WIDTH - 1));

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_state = state_ff;
      nxt_shreg = shreg_ff;
      nxt_half = half_ff;
      nxt_bits = bits_ff;
      case (state_ff)
         S_IDLE: begin
            if (start) begin
               nxt_state = S_LEAD;
               nxt_shreg = data;
               nxt_bits = 5'h00;
               nxt_half = 8'h00;
            end
         end
         // Sync leads the first clock edge by this whole cycle plus the first low half period
         S_LEAD: nxt_state = S_LOW;
         S_LOW: begin
            nxt_half = half_end ? 8'h00 : half_ff + 8'h01;
            if (half_end) begin
               nxt_state = S_HIGH;
            end
         end
         // Period 80, 80, 160 or 320 ns for divider 0 to 3
         S_HIGH: begin
            nxt_half = half_end ? 8'h00 : half_ff + 8'h01;
            if (half_end) begin
               nxt_bits = bits_ff + 5'h01;
               nxt_shreg = {shreg_ff[WIDTH-2:0], 1'b0};
               nxt_state = last_bit ? S_TAIL : S_LOW;
            end
         end
         // Sync held one cycle past the last falling edge
         S_TAIL: nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_ff <= S_IDLE;
         shreg_ff <= '0;
         half_ff <= 8'h00;
         bits_ff <= 5'h00;
         div_ff <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         shreg_ff <= nxt_shreg;
         half_ff <= nxt_half;
         bits_ff <= nxt_bits;
         if (start && state_ff == S_IDLE) begin
            div_ff <= div;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign ser.frame_sync = (state_ff != S_IDLE);
   assign ser.serial_data_clock = (state_ff == S_HIGH);
   assign ser.serial_data_out = shreg_ff[WIDTH-1];
   assign done = (state_ff == S_TAIL);
endmodule : adcrt_shifter

/* core/adcrt_top.sv */
// Conversion sequencer: busy timing, parallel result, master serial readout
`timescale 1ns/10ps
`include "adcrt_cfg.svh"
// Summary of operation
// - Busy high at most 850/1100/1350 ns, except in read-after where it covers the serial frame.
// - Parallel result valid by conversion time.
// - Result valid 20 ns before busy falls.
// - Read-during sync at 50/290/530 ns.
// - Read-after sync at 710/950/1190 ns.
// - Sync precedes first serial clock edge.
// - Sync falls after last serial edge.
// - Divider sets minimum serial clock period in read-after; read-during always uses setting 00.
// - Divider sets maximum serial clock period in read-after only.
// - Read-after busy covers whole serial transfer.
// - Read-after busy falls one cycle after sync falls.
// - Chip select high floats serial outputs.
// - Chip select low drives serial clock.
module adcrt_top #(
   parameter int WIDTH = `ADCRT_RES_BITS
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic conversion_start_strobe,
   input wire logic chip_select_n,
   input wire adcrt_pkg::adcrt_speed_t speed_mode,
   input wire adcrt_pkg::adcrt_read_t read_mode,
   input wire logic [1:0] serial_clock_divider,
   input wire logic [WIDTH-1:0] conv_result,
   output logic busy,
   output logic [WIDTH-1:0] data_bus,
   output logic frame_sync_o,
   output logic frame_sync_oe_n,
   output logic serial_data_clock_o,
   output logic serial_data_clock_oe_n,
   output logic serial_data_out_o,
   output logic serial_data_out_oe_n
);
   typedef enum logic [3:0] {
      C_IDLE = 4'h1,
      C_CONV = 4'h2,
      C_XFER = 4'h4,
      C_DROP = 4'h8
   } adcrt_state_t;

   adcrt_state_t state_ff, nxt_state;
   logic [2:0] start_sync_ff;
   logic start_prev_ff;
   logic [6:0] cnt_ff, nxt_cnt;
   logic [WIDTH-1:0] result_ff;
   adcrt_pkg::adcrt_read_t read_ff;
   adcrt_pkg::adcrt_speed_t speed_ff;
   adcrt_pkg::adcrt_ser_t ser;
   logic ser_done;

   function automatic logic [6:0] pick(input adcrt_pkg::adcrt_speed_t s, input int f, input int n, input int l);
      case (s)
         adcrt_pkg::ADCRT_SPD_FAST: pick = 7'(f);
         adcrt_pkg::ADCRT_SPD_NORM: pick = 7'(n);
         default: pick = 7'(l);
      endcase
   endfunction : pick

   ////////////////////////////////////////////////////////////////////////
   // Strobe pin: three stages, edge counted when stages two and three agree
   wire logic start_stable = (start_sync_ff[1] == start_sync_ff[2]);
   wire logic start_fall = start_stable && !start_sync_ff[2] && start_prev_ff;
   wire logic take_start = start_fall && (state_ff == C_IDLE);

   wire logic [6:0] conv_cyc = pick(speed_ff, `ADCRT_CONV_FAST_CYC, `ADCRT_CONV_NORM_CYC,
                                    `ADCRT_CONV_LOWP_CYC);
   wire logic [6:0] sdur_cyc = pick(speed_ff, `ADCRT_SDUR_FAST_CYC, `ADCRT_SDUR_NORM_CYC,
                                    `ADCRT_SDUR_LOWP_CYC);
   wire logic [6:0] saft_cyc = pick(speed_ff, `ADCRT_SAFT_FAST_CYC, `ADCRT_SAFT_NORM_CYC,
                                    `ADCRT_SAFT_LOWP_CYC);
   wire logic in_conv = (state_ff == C_CONV);
   wire logic conv_end = in_conv && (cnt_ff == conv_cyc);
   // Latched early: the strobe synchroniser eats into the result deadline
   wire logic latch_now = in_conv && (cnt_ff == conv_cyc - 7'(`ADCRT_DLEAD_CYC) - 7'(`ADCRT_PIN_LAT_CYC));
   wire logic is_after = (read_ff == adcrt_pkg::ADCRT_RD_SER_AFTER);
   wire logic ser_go_dur = in_conv && (read_ff == adcrt_pkg::ADCRT_RD_SER_DURING)
                           && (cnt_ff == sdur_cyc);
   wire logic ser_go_aft = in_conv && is_after && (cnt_ff == saft_cyc);
   // Read-during sends the previous result, read-after the one resolving now
   wire logic [WIDTH-1:0] ser_data = is_after ? conv_result : result_ff;
   wire logic [1:0] ser_div = is_after ? serial_clock_divider : 2'h0;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         C_IDLE: begin
            if (take_start) begin
               nxt_state = C_CONV;
               nxt_cnt = 7'h01;
            end
         end
         C_CONV: begin
            nxt_cnt = cnt_ff + 7'h01;
            if (conv_end) begin
               nxt_state = is_after ? C_XFER : C_IDLE;
            end
         end
         // Busy rides through the frame; done marks the sync tail
         C_XFER: begin
            if (ser_done) begin
               nxt_state = C_DROP;
            end
         end
         // Sync already low here; busy falls one cycle later
         C_DROP: nxt_state = C_IDLE;
         default: nxt_state = C_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         start_sync_ff <= 3'h7;
         start_prev_ff <= 1'b1;
         state_ff <= C_IDLE;
         cnt_ff <= 7'h00;
         read_ff <= adcrt_pkg::ADCRT_RD_PAR;
         speed_ff <= adcrt_pkg::ADCRT_SPD_FAST;
      end else begin
         start_sync_ff <= {start_sync_ff[1:0], conversion_start_strobe};
         if (start_stable) begin
            start_prev_ff <= start_sync_ff[2];
         end
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         // Modes frozen per conversion so a mid-flight change cannot tear timing
         if (take_start) begin
            read_ff <= read_mode;
            speed_ff <= speed_mode;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         result_ff <= `ADCRT_RESULT_RST;
      end else if (latch_now) begin
         result_ff <= conv_result;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   adcrt_shifter #(
      .WIDTH(WIDTH)
   ) adcrt_shifter_inst (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(ser_go_dur || ser_go_aft),
      .data(ser_data),
      .div(ser_div),
      .ser(ser),
      .done(ser_done)
   );

   assign busy = (state_ff != C_IDLE);
   assign data_bus = result_ff;
   assign frame_sync_o = ser.frame_sync;
   assign serial_data_clock_o = ser.serial_data_clock;
   assign serial_data_out_o = ser.serial_data_out;
   // Enables follow the pin with no flop so release stays within one gate delay
   assign frame_sync_oe_n = chip_select_n;
   assign serial_data_clock_oe_n = chip_select_n;
   assign serial_data_out_oe_n = chip_select_n;
endmodule : adcrt_top

/* tb/adcrt_checker.sv */
// Concurrent timing checks on the conversion sequencer ports
`timescale 1ns/10ps
module adcrt_checker #(
   parameter int WIDTH = 14
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic chip_select_n,
   input wire adcrt_pkg::adcrt_speed_t speed_mode,
   input wire adcrt_pkg::adcrt_read_t read_mode,
   input wire logic [1:0] serial_clock_divider,
   input wire logic busy,
   input wire logic [WIDTH-1:0] data_bus,
   input wire logic frame_sync_o,
   input wire logic frame_sync_oe_n,
   input wire logic serial_data_clock_o,
   input wire logic serial_data_clock_oe_n,
   input wire logic serial_data_out_oe_n
);
   default clocking dcb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   logic aft;
   logic [8:0] spd;
   logic [8:0] bcnt_ff;
   logic [3:0] hcnt_ff;
   logic [3:0] hexp;
   assign aft = read_mode == adcrt_pkg::ADCRT_RD_SER_AFTER;
   // Six cycles per speed step
   assign spd = (speed_mode == adcrt_pkg::ADCRT_SPD_FAST) ? 9'h000 :
      (speed_mode == adcrt_pkg::ADCRT_SPD_NORM) ? 9'h006 : 9'h00C;
   // High cycles that put 80 * n ns inside each divider's period window
   assign hexp = !aft ? 4'h1 : (serial_clock_divider == 2'h3) ? 4'h4 :
      (serial_clock_divider == 2'h2) ? 4'h2 : 4'h1;
   always_ff @(posedge clk_sys) begin
      bcnt_ff <= (rst_n && busy) ? bcnt_ff + 9'h001 : 9'h000;
      hcnt_ff <= (rst_n && serial_data_clock_o) ? hcnt_ff + 4'h1 : 4'h0;
   end
   ////////////////////////////////////////////////////////////////////////
   a_oe_follow: assert property (frame_sync_oe_n == chip_select_n
      && serial_data_out_oe_n == chip_select_n && serial_data_clock_oe_n == chip_select_n)
      else $error("enable differs from select");
   a_busy_width: assert property (busy && !aft |-> bcnt_ff <= 9'h014 + spd) else $error("busy too long");
   a_data_lead: assert property ($fell(busy) |-> $stable(data_bus)) else $error("data moved as busy fell");
   a_sync_during: assert property ($rose(frame_sync_o) && !aft
      |-> (bcnt_ff - spd) inside {9'h001, 9'h002}) else $error("early or late sync in read during");
   a_sync_after: assert property ($rose(frame_sync_o) && aft
      |-> (bcnt_ff - spd) inside {9'h011, 9'h012}) else $error("early or late sync in read after");
   a_clock_lead: assert property ($rose(frame_sync_o) |-> !serial_data_clock_o ##1 !serial_data_clock_o)
      else $error("clock edge too close to sync");
   a_clock_tail: assert property ($fell(frame_sync_o) |-> !$past(serial_data_clock_o))
      else $error("sync fell on clock edge");
   a_half_period: assert property ($fell(serial_data_clock_o) |-> hcnt_ff == hexp)
      else $error("serial clock high phase wrong");
   a_busy_cover: assert property (frame_sync_o && aft |-> busy) else $error("busy low in frame");
   a_busy_release: assert property ($fell(frame_sync_o) && aft |-> busy ##1 !busy)
      else $error("busy not one cycle after sync");
   c_par_done: cover property ($fell(busy) && read_mode == adcrt_pkg::ADCRT_RD_PAR);
   c_during: cover property ($rose(frame_sync_o) && !aft);
   c_after: cover property ($fell(frame_sync_o) && aft && serial_clock_divider == 2'h3);
endmodule : adcrt_checker
bind adcrt_top adcrt_checker #(.WIDTH(WIDTH)) adcrt_checker_inst (.clk_sys, .rst_n, .chip_select_n, .speed_mode,
   .read_mode, .serial_clock_divider, .busy, .data_bus, .frame_sync_o, .frame_sync_oe_n, .serial_data_clock_o,
   .serial_data_clock_oe_n, .serial_data_out_oe_n);

/* tb/adcrt_host_model.sv */
// Host reader that collects master serial frames
`timescale 1ns/10ps
module adcrt_host_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire adcrt_pkg::adcrt_ser_t ser,
   output logic [13:0] word_ff,
   output logic [4:0] bits_ff,
   output logic word_valid_ff
);
   logic sync_q_ff;
   logic sclk_q_ff;
   always_ff @(posedge clk_sys) begin
      sync_q_ff <= ser.frame_sync;
      sclk_q_ff <= ser.serial_data_clock;
      // Empty frames come from select changes on released lines
      word_valid_ff <= rst_n && sync_q_ff && !ser.frame_sync && bits_ff != 5'h00;
      if (!rst_n || (ser.frame_sync && !sync_q_ff)) begin
         bits_ff <= 5'h00;
      end else if (ser.frame_sync && ser.serial_data_clock && !sclk_q_ff) begin
         word_ff <= {word_ff[12:0], ser.serial_data_out};
         bits_ff <= bits_ff + 5'h01;
      end
   end
endmodule : adcrt_host_model

/* tb/tb_adcrt_top.sv */
// Self-checking bench for the conversion readout sequencer
`timescale 1ns/10ps
`include "adcrt_cfg.svh"
module tb_adcrt_top;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic conversion_start_strobe = 1'b1;
   logic chip_select_n = 1'b0;
   adcrt_pkg::adcrt_speed_t speed_mode = adcrt_pkg::ADCRT_SPD_FAST;
   adcrt_pkg::adcrt_read_t read_mode = adcrt_pkg::ADCRT_RD_PAR;
   logic [1:0] serial_clock_divider = 2'h0;
   logic [13:0] conv_result = 14'h0000;
   logic busy, frame_sync_o, frame_sync_oe_n, serial_data_clock_o, serial_data_clock_oe_n;
   logic serial_data_out_o, serial_data_out_oe_n, word_valid;
   logic busy_q = 1'b0;
   logic [13:0] data_bus, word;
   logic [13:0] prev = 14'h0000;
   logic [4:0] bits;
   logic [13:0] exp_par[$], exp_ser[$];
   int exp_len[$];
   int bad_count = 0, compares = 0, busy_len = 0, len;
   adcrt_pkg::adcrt_ser_t ser;
   // Released line shows the inverse, no pull on these wires
   assign ser = {frame_sync_o ^ frame_sync_oe_n, serial_data_clock_o ^ serial_data_clock_oe_n,
      serial_data_out_o ^ serial_data_out_oe_n};
   adcrt_top adcrt_top_inst (.clk_sys, .rst_n, .conversion_start_strobe, .chip_select_n, .speed_mode, .read_mode,
      .serial_clock_divider, .conv_result, .busy, .data_bus, .frame_sync_o, .frame_sync_oe_n, .serial_data_clock_o,
      .serial_data_clock_oe_n, .serial_data_out_o, .serial_data_out_oe_n);
   adcrt_host_model adcrt_host_model_inst (.clk_sys, .rst_n, .ser, .word_ff(word), .bits_ff(bits),
      .word_valid_ff(word_valid));
   initial forever #20 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test
   // Results are compared mid-cycle, once the edge's updates have landed
   always @(negedge clk_sys) begin
      if (busy === 1'b1) busy_len++;
      if (busy_q && busy === 1'b0) begin
         if (exp_par.size() == 0) begin
            chk("spurious busy", 16'h0000, 16'h0001);
         end else begin
            chk("parallel result", exp_par.pop_front(), data_bus);
            len = exp_len.pop_front();
            if (len != 0) chk("busy width", 16'(len), 16'(busy_len));
         end
         busy_len = 0;
      end
      busy_q = busy === 1'b1;
      if (word_valid === 1'b1) begin
         chk("serial bits", 16'h000E, bits);
         chk("serial word", exp_ser.size() ? exp_ser.pop_front() : ~word, word);
      end
   end
   task automatic conv(input int s, input int r, input int d, input bit ign);
      logic [13:0] v;
      int n;
      int cyc;
      v = 14'($urandom);
      n = 0;
      cyc = s == 0 ? `ADCRT_CONV_FAST_CYC : s == 1 ? `ADCRT_CONV_NORM_CYC : `ADCRT_CONV_LOWP_CYC;
      @(negedge clk_sys);
      speed_mode = adcrt_pkg::adcrt_speed_t'(s);
      read_mode = adcrt_pkg::adcrt_read_t'(r);
      serial_clock_divider = 2'(d);
      conv_result = v;
      chip_select_n = r % 3 == 0;
      conversion_start_strobe = 1'b0;
      exp_par.push_back(v);
      exp_len.push_back(r == 2 ? 0 : cyc);
      if (r == 1) exp_ser.push_back(prev);
      if (r == 2) exp_ser.push_back(v);
      prev = v;
      repeat (2) @(negedge clk_sys);
      conversion_start_strobe = 1'b1;
      // Deadline counted from the strobe's falling edge, not from busy
      if (!ign) begin
         repeat (cyc - 2) @(negedge clk_sys);
         chk("result latency", v, data_bus);
      end
      while (busy !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      if (ign) begin
         conversion_start_strobe = 1'b0;
         repeat (3) @(negedge clk_sys);
         conversion_start_strobe = 1'b1;
      end
      while ((busy !== 1'b0 || frame_sync_o !== 1'b0) && n < 500) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 500) begin
         bad_count++;
         stop_test();
      end
      repeat (40) @(negedge clk_sys);
      chk("held result", v, data_bus);
      $display("test done speed %0d read %0d divider %0d", s, r, d);
   endtask : conv
   initial begin
      void'($urandom(44));
      repeat (16) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      for (int s = 0; s < 3; s++) begin
         for (int r = 0; r < 4; r++) begin
            conv(s, r, s + r, r == 0);
         end
      end
      for (int d = 0; d < 4; d++) begin
         conv(0, 2, d, 1'b0);
      end
      // Mid-run reset clears the held result
      rst_n = 1'b0;
      repeat (4) @(negedge clk_sys);
      rst_n = 1'b1;
      prev = 14'h0000;
      conv(1, 1, 0, 1'b0);
      chk("pending results", 16'h0000, 16'(exp_par.size() + exp_ser.size()));
      stop_test();
   end
endmodule : tb_adcrt_top
